/* File: verilog/itfd_decoder.sv */
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Each terminal has a 6-bit code selecting one action; code 0 does nothing.
// - Codes 1-3 act only while run command source is terminals.
// - Code 6 blocks output at once and refuses start while held.
// - Code 7 resets faults once per rising edge, never on a level.
// - Code 8 faults when off, code 9 when on; fault raises event.
// - Code 10 raises, 11 lowers the offset; code 12 clears it for good.
// - Code 13 hides the offset while held; released, the offset returns.
// - Codes 14 low and 15 high pick one of four ramp time sets.
// - Codes 16 to 19 form a 4-bit step index, 16 being bit 0.
// - Code 20 holds the current step whatever other inputs do.
// - Code 21 swaps A and B while held; 22 and 23 idle under A.
// - Codes 22 and 23 swap A+B with A or B while held.
// - Code 24 pulse from all-open closes the three drive contactors.
// - Code 25 pulse from all-open closes only the bypass contactor.
// - Code 26 pulse moves from drive path to bypass, else ignored.
// - Code 27 pulse moves from bypass to drive path, else ignored.
// - Codes 24-27 act only with an automatic switch cabinet fitted.
// - Code 28 pulse commands automatic power cut-off.
// - Code 29 suspends PID while held; frequency hold comes from code 20 only.
// - Codes 32-34 form a 3-bit cabinet address, cabinets 1 to 8.
// - Codes 35-37 force source to panel, terminals, comms, only when remote.
// - Code 40 switches from torque to speed control while held.
// - A 16-bit polarity word inverts terminals; bit 0 is terminal 1.
// - All terminals pass a digital filter set 1 to 500, default 20.
module itfd_decoder #(
  parameter int FILTER_UNIT = itfd_pkg::FILTER_UNIT_CYCLES,
  parameter int UPDN_STEP = itfd_pkg::UPDN_STEP_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Field terminals
  input wire logic [itfd_pkg::NTERM-1:0] digital_input_terminals,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  // Decoded commands
  output itfd_pkg::itfd_cmd_s cmd
);
  localparam int N = itfd_pkg::NTERM;
  localparam int CW = itfd_pkg::CODE_W;

  // Terminals whose code equals c; code 0 and reserved codes are never looked up
  function automatic logic [N-1:0] code_mask(input logic [N*CW-1:0] f, input logic [CW-1:0] c);
    logic [N-1:0] m;
    m = '0;
    for (int i = 0; i < N; i++)
    begin
      m[i] = (f[i*CW +: CW] == c);
    end
    return m;
  endfunction

  logic [N*CW-1:0] func_q;
  logic [15:0] polarity_q;
  logic [8:0] filter_q;
  itfd_pkg::itfd_cfg_s cfg_q;

  // Register writes
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      func_q <= '0;
      polarity_q <= itfd_pkg::POLARITY_RST;
      filter_q <= itfd_pkg::FILTER_RST;
      cfg_q <= '0;
    end
    else if (wr)
    begin
      if (addr < itfd_pkg::REG_POLARITY)
      begin
        func_q[addr[3:0]*CW +: CW] <= wdata[CW-1:0];
      end
      else if (addr == itfd_pkg::REG_POLARITY)
      begin
        polarity_q <= wdata;
      end
      else if (addr == itfd_pkg::REG_FILTER)
      begin
        // Out-of-range settings clamp instead of disabling the filter
        if (wdata[15:9] != '0 || wdata[8:0] > itfd_pkg::FILTER_MAX)
        begin
          filter_q <= itfd_pkg::FILTER_MAX;
        end
        else if (wdata[8:0] < itfd_pkg::FILTER_MIN)
        begin
          filter_q <= itfd_pkg::FILTER_MIN;
        end
        else
        begin
          filter_q <= wdata[8:0];
        end
      end
      else if (addr == itfd_pkg::REG_CONFIG)
      begin
        cfg_q <= wdata[$bits(itfd_pkg::itfd_cfg_s)-1:0];
      end
    end
  end

  // Two-stage synchroniser for field pins
  logic [N-1:0] sync1_q;
  logic [N-1:0] sync2_q;
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
    end
    else
    begin
      sync1_q <= digital_input_terminals;
      sync2_q <= sync1_q;
    end
  end

  // Filter time base
  logic [$clog2(FILTER_UNIT+1)-1:0] unit_cnt_q;
  logic unit_tick;
  assign unit_tick = (unit_cnt_q == ($clog2(FILTER_UNIT+1))'(FILTER_UNIT - 1));
  always_ff @(posedge clk)
  begin
    if (!rstn || unit_tick)
    begin
      unit_cnt_q <= '0;
    end
    else
    begin
      unit_cnt_q <= unit_cnt_q + 1'b1;
    end
  end

  // Per-terminal debounce: a new level must hold for the filter time
  logic [N-1:0] stable_q;
  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : g_filt
      logic [8:0] cnt_q;
      logic st_q;
      // One process per bit keeps a single driver on each filtered level
      assign stable_q[g] = st_q;
      always_ff @(posedge clk)
      begin
        if (!rstn)
        begin
          cnt_q <= '0;
          st_q <= 1'b0;
        end
        else if (sync2_q[g] == st_q)
        begin
          cnt_q <= '0;
        end
        else if (unit_tick)
        begin
          if (cnt_q + 9'h001 >= filter_q)
          begin
            st_q <= sync2_q[g];
            cnt_q <= '0;
          end
          else
          begin
            cnt_q <= cnt_q + 9'h001;
          end
        end
      end
    end
  endgenerate

  logic [N-1:0] lvl;
  logic [N-1:0] prev_q;
  logic [N-1:0] rise;
  assign lvl = stable_q ^ polarity_q;
  assign rise = lvl & ~prev_q;
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      prev_q <= '0;
    end
    else
    begin
      prev_q <= lvl;
    end
  end

  function automatic logic on(input logic [N-1:0] v, input logic [N*CW-1:0] f,
                              input logic [CW-1:0] c);
    return |(v & code_mask(f, c));
  endfunction

  // Command source with remote forcing
  logic [1:0] src;
  always_comb
  begin
    src = cfg_q.cmd_src;
    if (cfg_q.remote)
    begin
      if (on(lvl, func_q, itfd_pkg::F_SRC_LOCAL))
      begin
        src = itfd_pkg::SRC_LOCAL;
      end
      else if (on(lvl, func_q, itfd_pkg::F_SRC_TERM))
      begin
        src = itfd_pkg::SRC_TERM;
      end
      else if (on(lvl, func_q, itfd_pkg::F_SRC_COMM))
      begin
        src = itfd_pkg::SRC_COMM;
      end
    end
  end

  logic src_term;
  logic coast;
  logic fault_now;
  logic fault_q;
  assign src_term = (src == itfd_pkg::SRC_TERM);
  assign coast = on(lvl, func_q, itfd_pkg::F_COAST);
  // NO input faults when open, NC input when closed
  assign fault_now = on(~lvl, func_q, itfd_pkg::F_EXT_NO) ||
                     on(lvl, func_q, itfd_pkg::F_EXT_NC);

  // Frequency channel
  logic [1:0] chan;
  always_comb
  begin
    chan = cfg_q.base_chan;
    unique case (cfg_q.base_chan)
      itfd_pkg::CH_A:
      begin
        if (on(lvl, func_q, itfd_pkg::F_SW_AB))
        begin
          chan = itfd_pkg::CH_B;
        end
      end
      itfd_pkg::CH_B:
      begin
        if (on(lvl, func_q, itfd_pkg::F_SW_AB))
        begin
          chan = itfd_pkg::CH_A;
        end
      end
      itfd_pkg::CH_SUM:
      begin
        if (on(lvl, func_q, itfd_pkg::F_SW_SUM_A))
        begin
          chan = itfd_pkg::CH_A;
        end
        else if (on(lvl, func_q, itfd_pkg::F_SW_SUM_B))
        begin
          chan = itfd_pkg::CH_B;
        end
      end
      default:
      begin
        chan = cfg_q.base_chan;
      end
    endcase
  end

  // Up/down accumulator
  logic [$clog2(UPDN_STEP+1)-1:0] rate_cnt_q;
  logic rate_tick;
  logic [15:0] updn_q;
  assign rate_tick = (rate_cnt_q == ($clog2(UPDN_STEP+1))'(UPDN_STEP - 1));
  always_ff @(posedge clk)
  begin
    if (!rstn || rate_tick)
    begin
      rate_cnt_q <= '0;
    end
    else
    begin
      rate_cnt_q <= rate_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn || on(lvl, func_q, itfd_pkg::F_UD_CLR))
    begin
      updn_q <= '0;
    end
    else if (rate_tick)
    begin
      if (on(lvl, func_q, itfd_pkg::F_UP) && updn_q != itfd_pkg::UPDN_MAX)
      begin
        updn_q <= updn_q + 16'h0001;
      end
      else if (on(lvl, func_q, itfd_pkg::F_DOWN) && updn_q != itfd_pkg::UPDN_MIN)
      begin
        updn_q <= updn_q - 16'h0001;
      end
    end
  end

  // Step index frozen by the hold terminal
  logic [3:0] step_q;
  logic step_hold;
  assign step_hold = on(lvl, func_q, itfd_pkg::F_STEP_HOLD);
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      step_q <= '0;
    end
    else if (!step_hold)
    begin
      for (int b = 0; b < 4; b++)
      begin
        step_q[b] <= on(lvl, func_q, itfd_pkg::F_STEP0 + CW'(b));
      end
    end
  end

  // Switch cabinet contactors: drive path (a,b,c) and bypass
  logic [2:0] path_q;
  logic bypass_q;
  logic all_open;
  logic on_path;
  logic on_line;
  assign all_open = (path_q == 3'h0) && !bypass_q;
  assign on_path = (path_q == 3'h7) && !bypass_q;
  assign on_line = (path_q == 3'h0) && bypass_q;
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      path_q <= '0;
      bypass_q <= 1'b0;
    end
    else if (cfg_q.cabinet_fitted)
    begin
      if (on(rise, func_q, itfd_pkg::F_VF_RUN) && all_open)
      begin
        path_q <= 3'h7;
      end
      else if (on(rise, func_q, itfd_pkg::F_LINE_RUN) && all_open)
      begin
        bypass_q <= 1'b1;
      end
      else if (on(rise, func_q, itfd_pkg::F_VF_TO_LINE) && on_path)
      begin
        path_q <= 3'h0;
        bypass_q <= 1'b1;
      end
      else if (on(rise, func_q, itfd_pkg::F_LINE_TO_VF) && on_line)
      begin
        path_q <= 3'h7;
        bypass_q <= 1'b0;
      end
    end
  end

  // Registered command outputs
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      cmd <= '0;
      fault_q <= 1'b0;
    end
    else
    begin
      fault_q <= fault_now;
      // A held coast terminal masks every run request except three-wire
      cmd.fwd_run <= src_term && !coast && on(lvl, func_q, itfd_pkg::F_FWD);
      cmd.rev_run <= src_term && !coast && on(lvl, func_q, itfd_pkg::F_REV);
      cmd.three_wire <= src_term && on(lvl, func_q, itfd_pkg::F_3WIRE);
      cmd.jog_fwd <= !coast && on(lvl, func_q, itfd_pkg::F_JOG_FWD);
      cmd.jog_rev <= !coast && on(lvl, func_q, itfd_pkg::F_JOG_REV);
      cmd.coast_stop <= coast;
      cmd.start_inhibit <= coast;
      cmd.fault_reset <= on(rise, func_q, itfd_pkg::F_FRESET);
      cmd.ext_fault <= fault_now;
      cmd.ext_fault_event <= fault_now && !fault_q;
      cmd.updn_offset <= on(lvl, func_q, itfd_pkg::F_UD_TMP) ? '0 : updn_q;
      cmd.ramp_time_set <= {on(lvl, func_q, itfd_pkg::F_RAMP1),
                            on(lvl, func_q, itfd_pkg::F_RAMP0)};
      cmd.step_index <= step_q;
      cmd.freq_hold <= step_hold;
      cmd.freq_chan <= chan;
      cmd.drive_path_contactor_a <= path_q[0];
      cmd.drive_path_contactor_b <= path_q[1];
      cmd.drive_path_contactor_c <= path_q[2];
      cmd.line_bypass_contactor <= bypass_q;
      cmd.power_cut <= on(rise, func_q, itfd_pkg::F_HV_BREAK);
      cmd.pid_pause <= on(lvl, func_q, itfd_pkg::F_PID_PAUSE);
      for (int b = 0; b < 3; b++)
      begin
        cmd.cabinet_addr[b] <= on(lvl, func_q, itfd_pkg::F_ADDR0 + CW'(b));
      end
      cmd.cmd_src <= src;
      cmd.speed_mode <= on(lvl, func_q, itfd_pkg::F_SPEED_MODE);
    end
  end

  // Read port, data in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      rdata <= '0;
    end
    else if (rd)
    begin
      if (addr < itfd_pkg::REG_POLARITY)
      begin
        rdata <= {10'h000, func_q[addr[3:0]*CW +: CW]};
      end
      else if (addr == itfd_pkg::REG_POLARITY)
      begin
        rdata <= polarity_q;
      end
      else if (addr == itfd_pkg::REG_FILTER)
      begin
        rdata <= {7'h00, filter_q};
      end
      else if (addr == itfd_pkg::REG_CONFIG)
      begin
        rdata <= {10'h000, cfg_q};
      end
      else if (addr == itfd_pkg::REG_STAT_LEVEL)
      begin
        rdata <= lvl;
      end
      else if (addr == itfd_pkg::REG_STAT_CMD)
      begin
        rdata <= {2'h0, step_q, chan, src, 2'h0, bypass_q, path_q};
      end
      else if (addr == itfd_pkg::REG_STAT_UPDN)
      begin
        rdata <= updn_q;
      end
      else
      begin
        rdata <= '0;
      end
    end
  end
endmodule // itfd_decoder
`default_nettype wire

/* File: verilog/itfd_pkg.sv */
`default_nettype none
package itfd_pkg;
  localparam int NTERM = 16;
  localparam int CODE_W = 6;
  // Function codes
  localparam logic [5:0] F_FWD = 6'h01;
  localparam logic [5:0] F_REV = 6'h02;
  localparam logic [5:0] F_3WIRE = 6'h03;
  localparam logic [5:0] F_JOG_FWD = 6'h04;
  localparam logic [5:0] F_JOG_REV = 6'h05;
  localparam logic [5:0] F_COAST = 6'h06;
  localparam logic [5:0] F_FRESET = 6'h07;
  localparam logic [5:0] F_EXT_NO = 6'h08;
  localparam logic [5:0] F_EXT_NC = 6'h09;
  localparam logic [5:0] F_UP = 6'h0A;
  localparam logic [5:0] F_DOWN = 6'h0B;
  localparam logic [5:0] F_UD_CLR = 6'h0C;
  localparam logic [5:0] F_UD_TMP = 6'h0D;
  localparam logic [5:0] F_RAMP0 = 6'h0E;
  localparam logic [5:0] F_RAMP1 = 6'h0F;
  localparam logic [5:0] F_STEP0 = 6'h10;
  localparam logic [5:0] F_STEP_HOLD = 6'h14;
  localparam logic [5:0] F_SW_AB = 6'h15;
  localparam logic [5:0] F_SW_SUM_A = 6'h16;
  localparam logic [5:0] F_SW_SUM_B = 6'h17;
  localparam logic [5:0] F_VF_RUN = 6'h18;
  localparam logic [5:0] F_LINE_RUN = 6'h19;
  localparam logic [5:0] F_VF_TO_LINE = 6'h1A;
  localparam logic [5:0] F_LINE_TO_VF = 6'h1B;
  localparam logic [5:0] F_HV_BREAK = 6'h1C;
  localparam logic [5:0] F_PID_PAUSE = 6'h1D;
  localparam logic [5:0] F_ADDR0 = 6'h20;
  localparam logic [5:0] F_SRC_LOCAL = 6'h23;
  localparam logic [5:0] F_SRC_TERM = 6'h24;
  localparam logic [5:0] F_SRC_COMM = 6'h25;
  localparam logic [5:0] F_SPEED_MODE = 6'h28;
  // Register word addresses
  localparam logic [7:0] REG_FUNC_BASE = 8'h00;
  localparam logic [7:0] REG_POLARITY = 8'h10;
  localparam logic [7:0] REG_FILTER = 8'h11;
  localparam logic [7:0] REG_CONFIG = 8'h12;
  localparam logic [7:0] REG_STAT_LEVEL = 8'h13;
  localparam logic [7:0] REG_STAT_CMD = 8'h14;
  localparam logic [7:0] REG_STAT_UPDN = 8'h15;
  // Reset values and limits
  localparam logic [15:0] POLARITY_RST = 16'h0000;
  localparam logic [8:0] FILTER_MIN = 9'h001;
  localparam logic [8:0] FILTER_MAX = 9'h1F4;
  localparam logic [8:0] FILTER_RST = 9'h014;
  localparam logic [15:0] UPDN_MAX = 16'h7FFF;
  localparam logic [15:0] UPDN_MIN = 16'h8001;
  // Timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int FILTER_UNIT_PS = 1000000;
  localparam int FILTER_UNIT_CYCLES = FILTER_UNIT_PS / CLK_PERIOD_PS;
  localparam int UPDN_STEP_PS = 1000000000;
  localparam int UPDN_STEP_CYCLES = UPDN_STEP_PS / CLK_PERIOD_PS;

  typedef enum logic [1:0] {SRC_LOCAL, SRC_TERM, SRC_COMM} itfd_src_e;
  typedef enum logic [1:0] {CH_A, CH_B, CH_SUM} itfd_chan_e;

  typedef struct packed {
    logic [1:0] base_chan;
    logic remote;
    logic cabinet_fitted;
    logic [1:0] cmd_src;
  } itfd_cfg_s;

  typedef struct packed {
    logic fwd_run;
    logic rev_run;
    logic three_wire;
    logic jog_fwd;
    logic jog_rev;
    logic coast_stop;
    logic start_inhibit;
    logic fault_reset;
    logic ext_fault;
    logic ext_fault_event;
    logic [15:0] updn_offset;
    logic [1:0] ramp_time_set;
    logic [3:0] step_index;
    logic freq_hold;
    logic [1:0] freq_chan;
    logic drive_path_contactor_a;
    logic drive_path_contactor_b;
    logic drive_path_contactor_c;
    logic line_bypass_contactor;
    logic power_cut;
    logic pid_pause;
    logic [2:0] cabinet_addr;
    logic [1:0] cmd_src;
    logic speed_mode;
  } itfd_cmd_s;
endpackage
`default_nettype wire

/* File: testbench/itfd_field.sv */
`timescale 1ns/1ps
`default_nettype none
module itfd_field (
  // Clock
  input wire logic clk,
  // Requested contact states and wired pins
  input wire logic [15:0] closed,
  output logic [15:0] pins
);
  // Contacts move on an edge; no bounce unless a scenario asks for it
  always_ff @(posedge clk)
  begin
    pins <= closed;
  end
endmodule // itfd_field
`default_nettype wire

/* File: testbench/itfd_decoder_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module itfd_decoder_properties (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Decoded commands
  input wire itfd_pkg::itfd_cmd_s cmd
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  a_fault_pulse_once: assert property (cmd.fault_reset |=> !cmd.fault_reset)
    else $error("fault reset pulse longer than one cycle");
  a_power_pulse_once: assert property (cmd.power_cut |=> !cmd.power_cut)
    else $error("power cut pulse longer than one cycle");
  a_ext_fault_event: assert property ($rose(cmd.ext_fault) |-> ##[0:1] cmd.ext_fault_event)
    else $error("external fault without event");
  a_coast_blocks_run: assert property (cmd.coast_stop |->
    !(cmd.fwd_run | cmd.rev_run | cmd.jog_fwd | cmd.jog_rev) && cmd.start_inhibit)
    else $error("run allowed during coast stop");
  a_run_source_gate: assert property (cmd.cmd_src != 2'h1 |->
    !(cmd.fwd_run | cmd.rev_run | cmd.three_wire))
    else $error("run command outside terminal source");
  a_path_together: assert property (cmd.drive_path_contactor_a == cmd.drive_path_contactor_b
    && cmd.drive_path_contactor_b == cmd.drive_path_contactor_c)
    else $error("drive path contactors disagree");
  a_bypass_exclusive: assert property (cmd.line_bypass_contactor |->
    !cmd.drive_path_contactor_a)
    else $error("bypass and drive path closed together");
  a_offset_bounds: assert property (cmd.updn_offset != 16'h8000)
    else $error("offset beyond saturation");
  a_hold_keeps_step: assert property (cmd.freq_hold && $past(cmd.freq_hold) |->
    $stable(cmd.step_index))
    else $error("step index moved during hold");
endmodule // itfd_decoder_properties

bind itfd_decoder itfd_decoder_properties itfd_decoder_properties_i (
  .clk(clk),
  .rstn(rstn),
  .cmd(cmd)
);
`default_nettype wire

/* File: testbench/tb_input_terminal_function_decoder.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) \
  begin \
    checks_done++; \
    if ((a) !== (e)) \
    begin \
      failures++; \
      $display("FAIL %0t got %h exp %h", $time, a, e); \
    end \
  end
module tb_input_terminal_function_decoder;
  localparam int UNIT = 4;
  localparam int SET = 2 + 2 * UNIT + 6;
  logic clk, rstn, wr, rd;
  logic [7:0] addr;
  logic [15:0] wdata, rdata, cl, pins;
  itfd_pkg::itfd_cmd_s cmd;
  int failures = 0, checks_done = 0, cyc = 0, n_fr = 0, n_pc = 0, n_ev = 0;

  itfd_field itfd_field_i (.clk(clk), .closed(cl), .pins(pins));
  itfd_decoder #(.FILTER_UNIT(UNIT), .UPDN_STEP(8)) itfd_decoder_i (
    .clk(clk), .rstn(rstn), .digital_input_terminals(pins), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .cmd(cmd));

  always #2.5 clk = ~clk;

  // One-cycle pulses are counted here so no scenario can miss them
  always @(posedge clk)
  begin
    cyc++;
    n_fr += (cmd.fault_reset === 1'b1);
    n_pc += (cmd.power_cut === 1'b1);
    n_ev += (cmd.ext_fault_event === 1'b1);
    if (cyc == 30000)
    begin
      failures++;
      end_sim();
    end
  end

  task automatic end_sim();
    if (failures == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic wreg(input logic [7:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rreg(input logic [7:0] a, input logic [15:0] e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    `CHK(rdata, e);
  endtask

  task automatic settle();
    repeat (SET) @(posedge clk);
  endtask

  task automatic code(input int t, input logic [5:0] c);
    wreg(itfd_pkg::REG_FUNC_BASE + 8'(t), {10'h000, c});
  endtask

  task automatic cfg(input logic [1:0] b, input logic rm, fit, input logic [1:0] s);
    wreg(itfd_pkg::REG_CONFIG, {10'h000, b, rm, fit, s});
    settle();
  endtask

  task automatic pin(input int i, input logic v);
    cl[i] <= v;
    settle();
  endtask

  task automatic pls(input int i);
    pin(i, 1'b1);
    pin(i, 1'b0);
  endtask

  task automatic clr();
    for (int i = 0; i < 16; i++)
      code(i, 6'h00);
    cl <= 16'h0000;
    cfg(2'h0, 1'b0, 1'b0, 2'h0);
  endtask

  task automatic t_regs();
    rreg(itfd_pkg::REG_FILTER, 16'h0014);
    rreg(itfd_pkg::REG_POLARITY, 16'h0000);
    rreg(8'hFF, 16'h0000);
    wreg(itfd_pkg::REG_FILTER, 16'h0000);
    rreg(itfd_pkg::REG_FILTER, 16'h0001);
    wreg(itfd_pkg::REG_FILTER, 16'h01FF);
    rreg(itfd_pkg::REG_FILTER, 16'h01F4);
    wreg(itfd_pkg::REG_FILTER, 16'h0001);
  endtask

  task automatic t_none();
    logic [5:0] rc [9] = '{6'h00, 6'h1E, 6'h1F, 6'h26, 6'h27, 6'h29, 6'h2A, 6'h2E, 6'h2F};
    for (int k = 0; k < 9; k++)
    begin
      code(0, rc[k]);
      rreg(itfd_pkg::REG_FUNC_BASE, {10'h000, rc[k]});
      pin(0, 1'b1);
      `CHK(cmd, '0);
      pin(0, 1'b0);
    end
  endtask

  task automatic t_run();
    for (int i = 0; i < 3; i++)
      code(i, 6'(i + 1));
    code(3, itfd_pkg::F_COAST);
    code(4, itfd_pkg::F_JOG_FWD);
    code(5, itfd_pkg::F_JOG_REV);
    cl <= 16'h0037;
    settle();
    `CHK({cmd.fwd_run, cmd.rev_run, cmd.three_wire}, 3'b000);
    `CHK({cmd.jog_fwd, cmd.jog_rev}, 2'b11);
    cfg(2'h0, 1'b0, 1'b0, 2'h1);
    `CHK({cmd.fwd_run, cmd.rev_run, cmd.three_wire}, 3'b111);
    pin(3, 1'b1);
    `CHK({cmd.fwd_run, cmd.coast_stop, cmd.start_inhibit}, 3'b011);
    `CHK({cmd.jog_fwd, cmd.jog_rev}, 2'b00);
    pin(3, 1'b0);
    `CHK(cmd.fwd_run, 1'b1);
    clr();
  endtask

  task automatic t_fault();
    int n, e;
    n = n_fr;
    e = n_ev;
    code(4, itfd_pkg::F_FRESET);
    pin(4, 1'b1);
    settle();
    `CHK(n_fr - n, 1);
    pin(4, 1'b0);
    pls(4);
    `CHK(n_fr - n, 2);
    code(5, itfd_pkg::F_EXT_NO);
    settle();
    `CHK(cmd.ext_fault, 1'b1);
    pin(5, 1'b1);
    `CHK(cmd.ext_fault, 1'b0);
    code(5, itfd_pkg::F_EXT_NC);
    settle();
    `CHK(cmd.ext_fault, 1'b1);
    `CHK(n_ev - e, 2);
    clr();
  endtask

  task automatic t_sel();
    code(0, itfd_pkg::F_RAMP0);
    code(1, itfd_pkg::F_RAMP1);
    for (int i = 0; i < 4; i++)
      code(2 + i, itfd_pkg::F_STEP0 + 6'(i));
    code(6, itfd_pkg::F_STEP_HOLD);
    for (int k = 0; k < 4; k++)
    begin
      cl <= 16'(k);
      settle();
      `CHK(cmd.ramp_time_set, 2'(k));
    end
    cl <= 16'h0028;
    settle();
    `CHK(cmd.step_index, 4'hA);
    pin(6, 1'b1);
    cl <= 16'h0044;
    settle();
    `CHK({cmd.freq_hold, cmd.step_index}, 5'h1A);
    pin(6, 1'b0);
    `CHK(cmd.step_index, 4'h1);
    clr();
  endtask

  task automatic chan(input logic [1:0] b, input logic [15:0] p, input logic [1:0] e);
    cfg(b, 1'b0, 1'b0, 2'h0);
    cl <= p;
    settle();
    `CHK(cmd.freq_chan, e);
  endtask

  task automatic t_chan();
    code(0, itfd_pkg::F_SW_AB);
    code(1, itfd_pkg::F_SW_SUM_A);
    code(2, itfd_pkg::F_SW_SUM_B);
    chan(2'h0, 16'h0001, 2'h1);
    chan(2'h0, 16'h0000, 2'h0);
    chan(2'h0, 16'h0006, 2'h0);
    chan(2'h1, 16'h0001, 2'h0);
    chan(2'h1, 16'h0000, 2'h1);
    chan(2'h2, 16'h0002, 2'h0);
    chan(2'h2, 16'h0004, 2'h1);
    chan(2'h2, 16'h0000, 2'h2);
    clr();
  endtask

  task automatic t_updn();
    logic [15:0] v;
    code(0, itfd_pkg::F_UP);
    code(1, itfd_pkg::F_DOWN);
    code(2, itfd_pkg::F_UD_CLR);
    code(3, itfd_pkg::F_UD_TMP);
    cl <= 16'h0001;
    repeat (80) @(posedge clk);
    pin(0, 1'b0);
    v = cmd.updn_offset;
    `CHK({v[15], v != 16'h0000}, 2'b01);
    pin(3, 1'b1);
    `CHK(cmd.updn_offset, 16'h0000);
    pin(3, 1'b0);
    `CHK(cmd.updn_offset, v);
    cl <= 16'h0002;
    repeat (40) @(posedge clk);
    pin(1, 1'b0);
    `CHK($signed(cmd.updn_offset) < $signed(v), 1'b1);
    pls(2);
    `CHK(cmd.updn_offset, 16'h0000);
    rreg(itfd_pkg::REG_STAT_UPDN, 16'h0000);
    clr();
  endtask

  function automatic logic [3:0] ct();
    return {cmd.line_bypass_contactor, cmd.drive_path_contactor_c,
      cmd.drive_path_contactor_b, cmd.drive_path_contactor_a};
  endfunction

  task automatic cab_codes();
    for (int i = 0; i < 4; i++)
      code(i, itfd_pkg::F_VF_RUN + 6'(i));
  endtask

  task automatic t_cab();
    cab_codes();
    pls(0);
    `CHK(ct(), 4'h0);
    cfg(2'h0, 1'b0, 1'b1, 2'h0);
    pls(2);
    pls(3);
    `CHK(ct(), 4'h0);
    pls(0);
    `CHK(ct(), 4'h7);
    pls(1);
    pls(0);
    `CHK(ct(), 4'h7);
    pls(2);
    `CHK(ct(), 4'h8);
    rreg(itfd_pkg::REG_STAT_CMD, 16'h0008);
    pls(0);
    pls(2);
    `CHK(ct(), 4'h8);
    pls(3);
    `CHK(ct(), 4'h7);
    rstn <= 1'b0;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    wreg(itfd_pkg::REG_FILTER, 16'h0001);
    cab_codes();
    cfg(2'h0, 1'b0, 1'b1, 2'h0);
    pls(1);
    `CHK(ct(), 4'h8);
    pls(3);
    `CHK(ct(), 4'h7);
    clr();
  endtask

  task automatic t_misc();
    int n;
    n = n_pc;
    code(0, itfd_pkg::F_HV_BREAK);
    code(1, itfd_pkg::F_PID_PAUSE);
    for (int i = 0; i < 3; i++)
      code(2 + i, itfd_pkg::F_ADDR0 + 6'(i));
    code(5, itfd_pkg::F_SPEED_MODE);
    for (int i = 0; i < 3; i++)
      code(6 + i, itfd_pkg::F_SRC_LOCAL + 6'(i));
    pls(0);
    `CHK(n_pc - n, 1);
    cl <= 16'h0036;
    settle();
    `CHK({cmd.pid_pause, cmd.cabinet_addr, cmd.speed_mode}, 5'b11011);
    cfg(2'h0, 1'b0, 1'b0, 2'h2);
    cl <= 16'h0040;
    settle();
    `CHK(cmd.cmd_src, 2'h2);
    cfg(2'h0, 1'b1, 1'b0, 2'h1);
    rreg(itfd_pkg::REG_CONFIG, 16'h0009);
    for (int j = 0; j < 3; j++)
    begin
      cl <= 16'h0040 << j;
      settle();
      `CHK(cmd.cmd_src, 2'(j));
    end
    clr();
  endtask

  task automatic t_pol();
    code(0, itfd_pkg::F_PID_PAUSE);
    code(15, itfd_pkg::F_SPEED_MODE);
    wreg(itfd_pkg::REG_POLARITY, 16'h8001);
    settle();
    `CHK({cmd.pid_pause, cmd.speed_mode}, 2'b11);
    rreg(itfd_pkg::REG_STAT_LEVEL, 16'h8001);
    wreg(itfd_pkg::REG_POLARITY, 16'h0000);
    wreg(itfd_pkg::REG_FILTER, 16'h0005);
    repeat (40) @(posedge clk);
    cl <= 16'h0001;
    repeat (6) @(posedge clk);
    cl <= 16'h0000;
    repeat (40) @(posedge clk);
    `CHK(cmd.pid_pause, 1'b0);
    cl <= 16'h0001;
    repeat (40) @(posedge clk);
    `CHK(cmd.pid_pause, 1'b1);
    wreg(itfd_pkg::REG_FILTER, 16'h0001);
    clr();
  endtask

  initial
  begin
    clk = 1'b0;
    rstn = 1'b0;
    addr = 8'h00;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    cl = 16'h0000;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_regs();
    t_none();
    t_run();
    t_fault();
    t_sel();
    t_chan();
    t_updn();
    t_cab();
    t_misc();
    t_pol();
    end_sim();
  end
endmodule // tb_input_terminal_function_decoder
`default_nettype wire
